// ### core/jct_consts.svh
// Constants for the configuration test access port: codes, widths and reset values.
`ifndef JCT_CONSTS_SVH
`define JCT_CONSTS_SVH
// ==========================================================
// Instruction codes
`define JCT_IR_W 8
`define JCT_OP_EXTEST 8'h00
`define JCT_OP_ADDR_SHIFT 8'h01
`define JCT_OP_DATA_SHIFT 8'h02
`define JCT_OP_BULK_ERASE 8'h03
`define JCT_OP_WRITE_COLUMN 8'h07
`define JCT_OP_SET_FUSE 8'h09
`define JCT_OP_READ_COLUMN 8'h0A
`define JCT_OP_DISCHARGE 8'h14
`define JCT_OP_PROG_ENABLE 8'h15
`define JCT_OP_IDCODE 8'h16
`define JCT_OP_USER_SIG 8'h17
`define JCT_OP_STORE_USER_SIG 8'h1A
`define JCT_OP_PROG_DISABLE 8'h1E
`define JCT_OP_HIGHZ 8'h18
`define JCT_OP_SAMPLE 8'h1C
`define JCT_OP_CLAMP 8'h20
`define JCT_OP_USER_RESET 8'h22
`define JCT_OP_INTEST 8'h2C
`define JCT_OP_CLEAR_VALID 8'h24
`define JCT_OP_WRITE_COLUMN_STEP 8'h27
`define JCT_OP_READ_COLUMN_STEP 8'h2A
`define JCT_OP_SET_VALID 8'h2F
`define JCT_OP_IDLE_PIN_HOLD 8'h30
`define JCT_IR_BYPASS_BIT 7
// ==========================================================
// Data register widths and reset values
`define JCT_ADDR_W 10
`define JCT_COL_W 89
`define JCT_ID_W 32
`define JCT_SIG_W 32
`define JCT_IR_CAPTURE 8'h16
`endif

// ### core/jct_pkg.sv
// Types for the configuration test access port.
package jct_pkg;
  // ==========================================================
  // Controller states, one-hot.
  typedef enum logic [15:0] {
    JCT_RESET = 16'h0001, JCT_IDLE = 16'h0002, JCT_SEL_DR = 16'h0004,
    JCT_CAP_DR = 16'h0008, JCT_SH_DR = 16'h0010, JCT_EX1_DR = 16'h0020,
    JCT_PAU_DR = 16'h0040, JCT_EX2_DR = 16'h0080, JCT_UPD_DR = 16'h0100,
    JCT_SEL_IR = 16'h0200, JCT_CAP_IR = 16'h0400, JCT_SH_IR = 16'h0800,
    JCT_EX1_IR = 16'h1000, JCT_PAU_IR = 16'h2000, JCT_EX2_IR = 16'h4000,
    JCT_UPD_IR = 16'h8000
  } jct_state_t;
endpackage

// ### core/jct_event_sync.sv
// Toggle-based event crossing from the test clock into the system clock.
`timescale 1ns/1ps
module jct_event_sync (
  // Source side
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_pulse,
  // Destination side
  input wire logic clock,
  input wire logic rst_n,
  output logic dst_pulse
);
  logic tog_r;
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ==========================================================
  // Each source pulse flips the toggle; a level survives any clock ratio.
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      tog_r <= 1'b0;
    end else if (src_pulse) begin
      tog_r <= ~tog_r;
    end
  end

  // Two stages resync, the third only serves the edge compare.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= tog_r;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign dst_pulse = s2_r ^ s3_r;
endmodule

// ### core/jct_tap.sv
// Test access port for boundary scan and configuration memory access.
//
// Functional notes
// - Sample inputs rising edge, drive output falling.
// - Sixteen-state controller steered by mode select.
// - Mode select high reaches reset within five.
// - Controller starts in reset after power-up.
// - Six states persist under a held level.
// - Reset exits to idle; idle does nothing.
// - Capture-DR loads ID, boundary, bypass in parallel; others keep.
// - Capture-IR loads the identification instruction.
// - Capture goes shift or exit1; then update/pause.
// - Pause holds path; exit2 to shift/update.
// - Memory operations start on idle entry.
// - Eight-bit IR; zero extest; top bit bypass.
// - Address and column data registers selectable.
// - Column write, optionally stepping the address.
// - Column read, optionally stepping the address.
// - Bulk erase and readout fuse set.
// - Program mode entered and left by instruction.
// - Identification register thirty-two bits.
// - User signature load, select, store.
// - High impedance, clamp, idle pin hold.
// - Pin sample and internal test.
// - Valid bit clear, set; supply discharge.
// - Memory operations need program mode.
// - User reset instruction resets user logic.
`timescale 1ns/1ps
`include "jct_consts.svh"
module jct_tap #(
  parameter int ADDR_W = `JCT_ADDR_W,
  parameter int COL_W = `JCT_COL_W,
  parameter int BSR_W = 16,
  parameter logic [31:0] ID_CODE = 32'h0000_0001 // Value is arbitrary.
) (
  // System clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Test link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Configuration memory, test clock domain
  output logic [ADDR_W-1:0] mem_addr,
  output logic [COL_W-1:0] mem_wdata,
  input wire logic [COL_W-1:0] mem_rdata,
  input wire logic [31:0] mem_sig_rdata,
  output logic [31:0] mem_sig_wdata,
  // Operation strobes, memory and other, system clock domain
  output logic op_write_column,
  output logic op_read_column,
  output logic op_bulk_erase,
  output logic op_set_fuse,
  output logic op_store_sig,
  output logic op_clear_valid,
  output logic op_set_valid,
  output logic op_discharge,
  output logic op_user_reset,
  // Pin control
  input wire logic [BSR_W-1:0] pin_in,
  output logic [BSR_W-1:0] pin_out,
  output logic pins_from_bsr,
  output logic pins_highz,
  output logic intest_mode,
  output logic prog_mode
);
  jct_pkg::jct_state_t st_r, st_nxt;
  logic [7:0] ir_sh_r, ir_r;
  logic [ADDR_W-1:0] addr_r;
  logic [COL_W-1:0] col_r;
  logic [31:0] id_sh_r, sig_r;
  logic [BSR_W-1:0] bsr_r, bsr_upd_r;
  logic byp_r, tdo_r, tdo_oe_r, prog_r, pend_r, step_r;
  logic [BSR_W-1:0] pin_s1_r, pin_s2_r;
  logic [7:0] pend_op_r;
  logic ev_write, ev_read, ev_erase, ev_fuse, ev_store, ev_clrv, ev_setv, ev_dis, ev_urst;

  // ==========================================================
  // Controller next state, standard graph.
  always_comb begin
    st_nxt = jct_pkg::JCT_RESET;
    case (st_r)
      jct_pkg::JCT_RESET: st_nxt = tms ? jct_pkg::JCT_RESET : jct_pkg::JCT_IDLE;
      jct_pkg::JCT_IDLE: st_nxt = tms ? jct_pkg::JCT_SEL_DR : jct_pkg::JCT_IDLE;
      jct_pkg::JCT_SEL_DR: st_nxt = tms ? jct_pkg::JCT_SEL_IR : jct_pkg::JCT_CAP_DR;
      jct_pkg::JCT_CAP_DR: st_nxt = tms ? jct_pkg::JCT_EX1_DR : jct_pkg::JCT_SH_DR;
      jct_pkg::JCT_SH_DR: st_nxt = tms ? jct_pkg::JCT_EX1_DR : jct_pkg::JCT_SH_DR;
      jct_pkg::JCT_EX1_DR: st_nxt = tms ? jct_pkg::JCT_UPD_DR : jct_pkg::JCT_PAU_DR;
      jct_pkg::JCT_PAU_DR: st_nxt = tms ? jct_pkg::JCT_EX2_DR : jct_pkg::JCT_PAU_DR;
      jct_pkg::JCT_EX2_DR: st_nxt = tms ? jct_pkg::JCT_UPD_DR : jct_pkg::JCT_SH_DR;
      jct_pkg::JCT_UPD_DR: st_nxt = tms ? jct_pkg::JCT_SEL_DR : jct_pkg::JCT_IDLE;
      jct_pkg::JCT_SEL_IR: st_nxt = tms ? jct_pkg::JCT_RESET : jct_pkg::JCT_CAP_IR;
      jct_pkg::JCT_CAP_IR: st_nxt = tms ? jct_pkg::JCT_EX1_IR : jct_pkg::JCT_SH_IR;
      jct_pkg::JCT_SH_IR: st_nxt = tms ? jct_pkg::JCT_EX1_IR : jct_pkg::JCT_SH_IR;
      jct_pkg::JCT_EX1_IR: st_nxt = tms ? jct_pkg::JCT_UPD_IR : jct_pkg::JCT_PAU_IR;
      jct_pkg::JCT_PAU_IR: st_nxt = tms ? jct_pkg::JCT_EX2_IR : jct_pkg::JCT_PAU_IR;
      jct_pkg::JCT_EX2_IR: st_nxt = tms ? jct_pkg::JCT_UPD_IR : jct_pkg::JCT_SH_IR;
      jct_pkg::JCT_UPD_IR: st_nxt = tms ? jct_pkg::JCT_SEL_DR : jct_pkg::JCT_IDLE;
      default: st_nxt = jct_pkg::JCT_RESET;
    endcase
  end

  // ==========================================================
  // Instruction decode.
  wire in_cap_dr = (st_r == jct_pkg::JCT_CAP_DR);
  wire in_sh_dr = (st_r == jct_pkg::JCT_SH_DR);
  wire in_upd_dr = (st_r == jct_pkg::JCT_UPD_DR);
  wire in_cap_ir = (st_r == jct_pkg::JCT_CAP_IR);
  wire in_sh_ir = (st_r == jct_pkg::JCT_SH_IR);
  wire in_upd_ir = (st_r == jct_pkg::JCT_UPD_IR);
  wire sel_bypass = ir_r[`JCT_IR_BYPASS_BIT];
  wire sel_addr = !sel_bypass && (ir_r == `JCT_OP_ADDR_SHIFT);
  wire sel_col = !sel_bypass && (ir_r == `JCT_OP_DATA_SHIFT ||
    ir_r == `JCT_OP_READ_COLUMN || ir_r == `JCT_OP_READ_COLUMN_STEP ||
    ir_r == `JCT_OP_WRITE_COLUMN || ir_r == `JCT_OP_WRITE_COLUMN_STEP);
  wire sel_id = (ir_r == `JCT_OP_IDCODE);
  wire sel_sig = (ir_r == `JCT_OP_USER_SIG) || (ir_r == `JCT_OP_STORE_USER_SIG);
  wire sel_bsr = (ir_r == `JCT_OP_EXTEST) || (ir_r == `JCT_OP_SAMPLE) ||
    (ir_r == `JCT_OP_INTEST);
  // Memory codes wait for the next idle entry, and then only in program mode.
  // An update that goes straight to idle decodes the fresh code, not the pending one.
  wire [7:0] op_code = in_upd_ir ? ir_sh_r : pend_op_r;
  wire is_mem_op = (op_code == `JCT_OP_BULK_ERASE) || (op_code == `JCT_OP_WRITE_COLUMN) ||
    (op_code == `JCT_OP_WRITE_COLUMN_STEP) || (op_code == `JCT_OP_SET_FUSE) ||
    (op_code == `JCT_OP_READ_COLUMN) || (op_code == `JCT_OP_READ_COLUMN_STEP) ||
    (op_code == `JCT_OP_STORE_USER_SIG);
  wire idle_entry = (st_nxt == jct_pkg::JCT_IDLE) && (st_r != jct_pkg::JCT_IDLE);
  // Leaving test reset never fires: the state test blocks it, as one cycle in reset leaves program mode still set.
  wire fire = (pend_r || in_upd_ir) && is_mem_op && idle_entry && prog_r &&
    (st_r != jct_pkg::JCT_RESET);
  wire t_write = fire && (op_code == `JCT_OP_WRITE_COLUMN ||
    op_code == `JCT_OP_WRITE_COLUMN_STEP);
  wire t_read = fire && (op_code == `JCT_OP_READ_COLUMN ||
    op_code == `JCT_OP_READ_COLUMN_STEP);
  wire t_step = t_write && op_code == `JCT_OP_WRITE_COLUMN_STEP ||
    t_read && op_code == `JCT_OP_READ_COLUMN_STEP;
  wire t_erase = fire && op_code == `JCT_OP_BULK_ERASE;
  wire t_fuse = fire && op_code == `JCT_OP_SET_FUSE;
  wire t_store = fire && op_code == `JCT_OP_STORE_USER_SIG;
  // Non-memory instructions act as the update state latches them.
  wire upd_new = in_upd_ir;
  wire t_clrv = upd_new && ir_sh_r == `JCT_OP_CLEAR_VALID && prog_r;
  wire t_setv = upd_new && ir_sh_r == `JCT_OP_SET_VALID && prog_r;
  wire t_dis = upd_new && ir_sh_r == `JCT_OP_DISCHARGE;
  wire t_urst = upd_new && ir_sh_r == `JCT_OP_USER_RESET;
  wire dr_tdo = sel_bypass ? byp_r : sel_addr ? addr_r[0] : sel_col ? col_r[0] :
    sel_id ? id_sh_r[0] : sel_sig ? sig_r[0] : sel_bsr ? bsr_r[0] : byp_r;

  // ==========================================================
  // State register; reset state at power-up.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= jct_pkg::JCT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Instruction shift path and latch.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_r <= `JCT_IR_CAPTURE;
      ir_r <= `JCT_OP_IDCODE;
    end else if (st_r == jct_pkg::JCT_RESET) begin
      ir_r <= `JCT_OP_IDCODE;
    end else if (in_cap_ir) begin
      ir_sh_r <= `JCT_IR_CAPTURE;
    end else if (in_sh_ir) begin
      ir_sh_r <= {tdi, ir_sh_r[7:1]};
    end else if (in_upd_ir) begin
      ir_r <= ir_sh_r;
    end
  end

  // Program mode follows enable and disable at update.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      prog_r <= 1'b0;
    end else if (st_r == jct_pkg::JCT_RESET) begin
      prog_r <= 1'b0;
    end else if (upd_new && ir_sh_r == `JCT_OP_PROG_ENABLE) begin
      prog_r <= 1'b1;
    end else if (upd_new && ir_sh_r == `JCT_OP_PROG_DISABLE) begin
      prog_r <= 1'b0;
    end
  end

  // Memory operation arms at update and fires once on idle entry.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      pend_op_r <= 8'h00;
    end else if (in_upd_ir) begin
      pend_r <= !idle_entry; // Consumed at once when the update goes straight to idle.
      pend_op_r <= ir_sh_r;
    end else if (idle_entry || st_r == jct_pkg::JCT_RESET) begin
      pend_r <= 1'b0;
    end
  end

  // Bypass bit.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      byp_r <= 1'b0;
    end else if (in_cap_dr) begin
      byp_r <= 1'b0;
    end else if (in_sh_dr) begin
      byp_r <= tdi;
    end
  end

  // The step waits one test clock so the strobe still sees the accessed column.
  // Limitation: with the test clock stopped in idle the step lands on its next edge.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      step_r <= 1'b0;
    end else begin
      step_r <= t_step;
    end
  end

  // Address register; capture keeps the value, stepping after access.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
    end else if (in_sh_dr && sel_addr) begin
      addr_r <= {tdi, addr_r[ADDR_W-1:1]};
    end else if (step_r) begin
      addr_r <= addr_r + 1'b1;
    end
  end

  // Column data register, loaded by a read operation.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      col_r <= '0;
    end else if (t_read) begin
      col_r <= mem_rdata;
    end else if (in_sh_dr && sel_col) begin
      col_r <= {tdi, col_r[COL_W-1:1]};
    end
  end

  // Identification shift path.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      id_sh_r <= '0;
    end else if (in_cap_dr && sel_id) begin
      id_sh_r <= ID_CODE;
    end else if (in_sh_dr && sel_id) begin
      id_sh_r <= {tdi, id_sh_r[31:1]};
    end
  end

  // User signature: loaded from memory when selected by its read code.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      sig_r <= '0;
    end else if (in_upd_ir && ir_sh_r == `JCT_OP_USER_SIG) begin
      sig_r <= mem_sig_rdata;
    end else if (in_sh_dr && sel_sig) begin
      sig_r <= {tdi, sig_r[31:1]};
    end
  end

  // Pins are asynchronous to the test clock, so a capture sees them two edges late.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Boundary register: pins captured, update latch drives clamped pins.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      bsr_r <= '0;
      bsr_upd_r <= '0;
    end else if (in_cap_dr && sel_bsr) begin
      bsr_r <= pin_s2_r;
    end else if (in_sh_dr && sel_bsr) begin
      bsr_r <= {tdi, bsr_r[BSR_W-1:1]};
    end else if (in_upd_dr && sel_bsr) begin
      bsr_upd_r <= bsr_r;
    end
  end

  // ==========================================================
  // Serial output changes on the falling edge; pause keeps it steady.
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r <= in_sh_ir ? ir_sh_r[0] : dr_tdo;
      tdo_oe_r <= in_sh_ir || in_sh_dr;
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;
  assign mem_addr = addr_r;
  assign mem_wdata = col_r;
  assign mem_sig_wdata = sig_r;
  assign prog_mode = prog_r;
  assign pin_out = bsr_upd_r;
  // Clamp and idle pin hold both drive from the boundary latch.
  assign pins_from_bsr = (ir_r == `JCT_OP_EXTEST) || (ir_r == `JCT_OP_CLAMP) ||
    (ir_r == `JCT_OP_IDLE_PIN_HOLD);
  assign pins_highz = (ir_r == `JCT_OP_HIGHZ);
  assign intest_mode = (ir_r == `JCT_OP_INTEST);

  // ==========================================================
  // Strobes cross to the system clock as toggles; the test clock may stop.
  logic [8:0] t_ev, s_ev;
  assign t_ev = {t_urst, t_dis, t_setv, t_clrv, t_store, t_fuse, t_erase, t_read, t_write};
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      jct_event_sync u_sync (
        .src_clk(tck),
        .src_rst_n(rst_n),
        .src_pulse(t_ev[gi]),
        .clock(clock),
        .rst_n(rst_n),
        .dst_pulse(s_ev[gi])
      );
    end
  endgenerate

  assign {ev_urst, ev_dis, ev_setv, ev_clrv, ev_store, ev_fuse, ev_erase, ev_read,
    ev_write} = s_ev;
  assign op_write_column = ev_write;
  assign op_read_column = ev_read;
  assign op_bulk_erase = ev_erase;
  assign op_set_fuse = ev_fuse;
  assign op_store_sig = ev_store;
  assign op_clear_valid = ev_clrv;
  assign op_set_valid = ev_setv;
  assign op_discharge = ev_dis;
  assign op_user_reset = ev_urst;
endmodule

// ### verif/jct_tap_monitor.sv
// Checker for the configuration test access port, bound to its top module.
`timescale 1ns/1ps
module jct_tap_monitor (
  // Clocks and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tck,
  // Test link
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdo_oe,
  // Operation strobes
  input wire logic op_write_column,
  input wire logic op_read_column,
  input wire logic op_bulk_erase,
  input wire logic op_set_fuse,
  input wire logic op_store_sig,
  input wire logic op_clear_valid,
  input wire logic op_set_valid,
  input wire logic op_discharge,
  input wire logic op_user_reset,
  // Mode levels
  input wire logic pins_from_bsr,
  input wire logic pins_highz,
  input wire logic intest_mode,
  input wire logic prog_mode
);
  // ==========================================================
  // Helpers
  // Strobes as one vector; the memory ones are the ones that need program mode.
  wire [8:0] ops = {op_user_reset, op_discharge, op_set_valid, op_clear_valid, op_store_sig,
                    op_set_fuse, op_bulk_erase, op_read_column, op_write_column};
  wire mem_op = |ops[6:0];
  logic live_tck_r, live_clk_r;
  // Past values sampled before a reset are stale, so history checks wait one edge.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) live_tck_r <= 1'b0;
    else live_tck_r <= 1'b1;
  end
  // Same guard for the system clock domain.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) live_clk_r <= 1'b0;
    else live_clk_r <= 1'b1;
  end
  sequence s_tck_high;
    live_clk_r && tck && $past(tck);
  endsequence
  sequence s_tms_high;
    tms [*6];
  endsequence
  // ==========================================================
  // Properties
  property p_tdo_edge;
    @(posedge clock) disable iff (!rst_n) s_tck_high |-> $stable(tdo) && $stable(tdo_oe);
  endproperty
  a_tdo_edge: assert property (p_tdo_edge)
    else $error("serial output moved while test clock high");
  property p_tms_reset;
    @(posedge tck) disable iff (!rst_n) s_tms_high |=> !prog_mode && !tdo_oe;
  endproperty
  a_tms_reset: assert property (p_tms_reset)
    else $error("mode select held high did not reset the controller");
  property p_shift_entry;
    @(posedge tck) disable iff (!rst_n) live_tck_r && $rose(tdo_oe) |-> !$past(tms);
  endproperty
  a_shift_entry: assert property (p_shift_entry)
    else $error("shift entered without mode select low");
  property p_shift_exit;
    @(posedge tck) disable iff (!rst_n) live_tck_r && $fell(tdo_oe) |-> $past(tms);
  endproperty
  a_shift_exit: assert property (p_shift_exit)
    else $error("shift left while mode select low");
  property p_pulse;
    @(posedge clock) disable iff (!rst_n) ops != 9'h000 |=> (ops == 9'h000) [*2];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("operation strobe longer than one cycle");
  property p_onehot;
    @(posedge clock) disable iff (!rst_n) $onehot0(ops);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("two operation strobes at once");
  property p_need_prog;
    @(posedge clock) disable iff (!rst_n) mem_op |-> prog_mode;
  endproperty
  a_need_prog: assert property (p_need_prog)
    else $error("memory operation outside program mode");
  property p_op_quiet;
    @(posedge clock) disable iff (!rst_n) ops != 9'h000 |-> !tdo_oe;
  endproperty
  a_op_quiet: assert property (p_op_quiet)
    else $error("operation strobe during a shift");
  property p_pin_mode;
    @(posedge clock) disable iff (!rst_n) $onehot0({pins_highz, pins_from_bsr, intest_mode});
  endproperty
  a_pin_mode: assert property (p_pin_mode)
    else $error("conflicting pin modes");
endmodule
bind jct_tap jct_tap_monitor u_mon (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms),
  .tdo(tdo), .tdo_oe(tdo_oe), .op_write_column(op_write_column),
  .op_read_column(op_read_column), .op_bulk_erase(op_bulk_erase), .op_set_fuse(op_set_fuse),
  .op_store_sig(op_store_sig), .op_clear_valid(op_clear_valid), .op_set_valid(op_set_valid),
  .op_discharge(op_discharge), .op_user_reset(op_user_reset), .pins_from_bsr(pins_from_bsr),
  .pins_highz(pins_highz), .intest_mode(intest_mode), .prog_mode(prog_mode));

// ### verif/jct_host_model.sv
// Model of the external test controller that drives the test link.
`timescale 1ns/1ps
module jct_host_model (
  // Test link
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // The link idles with the clock low; it only runs inside a call.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock: inputs set while low, output sampled at the rising edge.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = tdo;
    #62.5 tck = 1'b0;
  endtask
  // Mode select held high reaches reset, then one low step goes to idle.
  task automatic reset_tap();
    logic q;
    repeat (6) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
  // Scan from idle back to idle, LSB first, optionally pausing after bit pz.
  task automatic scan(input logic ir, input logic [88:0] din, input int n, input int pz,
                      output logic [88:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pz, din[i], q);
      dout[i] = q;
      if (i == pz) begin
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
      end
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule

// ### verif/jct_tap_tb_top.sv
// Self-checking testbench for the configuration test access port.
`timescale 1ns/1ps
module jct_tap_tb_top;
  localparam logic [31:0] ID_V = 32'h3C5A_0E71; // Value is arbitrary.
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, pins_from_bsr, pins_highz, intest_mode, prog_mode;
  logic [9:0] mem_addr;
  logic [88:0] mem_wdata, mem_rdata;
  logic [31:0] mem_sig_rdata, mem_sig_wdata;
  logic [15:0] pin_in, pin_out;
  wire [8:0] ops;
  wire [2:0] pmode = {pins_highz, pins_from_bsr, intest_mode};
  int cnt [9] = '{default: 0};
  int ntot = 0;
  int errors = 0;
  int n_checks = 0;
  // ==========================================================
  // Clock, design and link partner
  always #2.5 clock = ~clock;
  jct_tap #(.ID_CODE(ID_V)) u_dut (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_sig_rdata(mem_sig_rdata), .mem_sig_wdata(mem_sig_wdata),
    .op_write_column(ops[0]), .op_read_column(ops[1]), .op_bulk_erase(ops[2]),
    .op_set_fuse(ops[3]), .op_store_sig(ops[4]), .op_clear_valid(ops[5]),
    .op_set_valid(ops[6]), .op_discharge(ops[7]), .op_user_reset(ops[8]), .pin_in(pin_in),
    .pin_out(pin_out), .pins_from_bsr(pins_from_bsr), .pins_highz(pins_highz),
    .intest_mode(intest_mode), .prog_mode(prog_mode));
  // A released serial output shows the inverse, so a sample outside a shift fails.
  wire tdo_line = tdo_oe ? tdo : ~tdo;
  jct_host_model u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
  // Count strobes so each operation can be matched to exactly one pulse.
  always @(posedge clock) begin
    for (int k = 0; k < 9; k++) begin
      if (ops[k] === 1'b1) begin
        cnt[k]++;
        ntot++;
      end
    end
  end
  // ==========================================================
  // Expectations
  function automatic int op_idx(input logic [7:0] c);
    case (c)
      8'h07, 8'h27: return 0;
      8'h0A, 8'h2A: return 1;
      8'h03: return 2;
      8'h09: return 3;
      8'h1A: return 4;
      8'h24: return 5;
      8'h2F: return 6;
      8'h14: return 7;
      default: return 8;
    endcase
  endfunction
  // Pin modes in the order high impedance, from boundary, internal test.
  function automatic logic [2:0] pin_exp(input logic [7:0] c);
    return {c == 8'h18, c == 8'h00 || c == 8'h20 || c == 8'h30, c == 8'h2C};
  endfunction
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [88:0] e, input logic [88:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic ld(input logic [7:0] c);
    logic [88:0] q;
    u_host.scan(1'b1, 89'(c), 8, -1, q);
  endtask
  task automatic rnd_in();
    @(posedge clock);
    #1;
    mem_rdata = 89'({$urandom, $urandom, $urandom});
    mem_sig_rdata = $urandom;
    pin_in = 16'($urandom);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cut a hang short well after the expected run length.
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [88:0] q, d;
    logic [7:0] tab [11];
    logic [9:0] a;
    int k, b;
    tab = '{8'h07, 8'h27, 8'h0A, 8'h2A, 8'h03, 8'h09, 8'h1A, 8'h24, 8'h2F, 8'h14, 8'h22};
    mem_rdata = '0;
    mem_sig_rdata = '0;
    pin_in = '0;
    k = $urandom(32'h5DF9);
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    rnd_in();
    u_host.reset_tap();
    u_host.scan(1'b0, '0, 32, 9, q);
    chk("idcode", 89'(ID_V), 89'(q[31:0]));
    // Random bypass codes; each instruction scan also returns the capture value.
    for (int i = 0; i < 3; i++) begin
      u_host.scan(1'b1, 89'(8'h80 | 8'($urandom)), 8, -1, q);
      chk("ir_capture", 89'h16, 89'(q[7:0]));
      d = 89'($urandom);
      u_host.scan(1'b0, d, 17, -1, q);
      chk("bypass", 89'({d[15:0], 1'b0}), 89'(q[16:0]));
    end
    b = ntot;
    ld(8'h07);
    chk("refused", 89'(b), 89'(ntot));
    ld(8'h15);
    chk("prog_mode", 89'h1, 89'(prog_mode));
    ld(8'h01);
    a = 10'($urandom);
    u_host.scan(1'b0, 89'(a), 10, -1, q);
    chk("addr", 89'(a), 89'(mem_addr));
    ld(8'h02);
    d = 89'({$urandom, $urandom, $urandom});
    u_host.scan(1'b0, d, 89, 40, q);
    chk("wdata", d, mem_wdata);
    // Every strobing code once, each giving one pulse on its own strobe.
    foreach (tab[i]) begin
      k = cnt[op_idx(tab[i])];
      b = ntot;
      ld(tab[i]);
      chk("op_pulse", 89'(k + 1), 89'(cnt[op_idx(tab[i])]));
      chk("op_total", 89'(b + 1), 89'(ntot));
    end
    chk("addr_step", 89'(10'(a + 10'h2)), 89'(mem_addr));
    ld(8'h02);
    u_host.scan(1'b0, d, 89, -1, q);
    chk("rdata", mem_rdata, q);
    // Pin control codes, ending with the pin sample.
    tab = '{0: 8'h18, 1: 8'h20, 2: 8'h30, 3: 8'h2C, 4: 8'h00, 5: 8'h1C, default: 8'h00};
    for (int i = 0; i < 6; i++) begin
      ld(tab[i]);
      chk("pin_mode", 89'(pin_exp(tab[i])), 89'(pmode));
    end
    d = 89'($urandom);
    u_host.scan(1'b0, d, 16, -1, q);
    chk("sample", 89'(pin_in), 89'(q[15:0]));
    chk("pin_out", 89'(d[15:0]), 89'(pin_out));
    ld(8'h17);
    d = 89'($urandom);
    u_host.scan(1'b0, d, 32, -1, q);
    chk("sig_read", 89'(mem_sig_rdata), 89'(q[31:0]));
    chk("sig_write", 89'(d[31:0]), 89'(mem_sig_wdata));
    ld(8'h1E);
    chk("prog_off", 89'h0, 89'(prog_mode));
    b = ntot;
    ld(8'h07);
    chk("refused_off", 89'(b), 89'(ntot));
    ld(8'h15);
    u_host.reset_tap();
    chk("prog_reset", 89'h0, 89'(prog_mode));
    u_host.scan(1'b0, '0, 32, -1, q);
    chk("idcode_again", 89'(ID_V), 89'(q[31:0]));
    complete_run();
  end
endmodule
